// >>> rtl/fws_flash_ctrl.sv
// Purpose: Program/erase sequencer with its control registers
// Assumes: register port strobes one cycle long, never together
// Notes:   Suspend is honoured while locked, except in protection programming; erase steps one word a cycle
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module fws_flash_ctrl #(
  parameter int          SECT_WORDS  = 16,
  parameter logic [15:0] PROG_CYCLES = fws_pkg::PROG_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire fws_pkg::fws_bus_req_t bus_req,
  input  wire logic                  bootstrap,
  input  wire logic                  bank_rd,
  input  wire fws_pkg::fws_addr_t    bank_addr,
  output var  logic [15:0]           rdata_ff,
  output var  logic                  trap_ff,
  output var  logic [15:0]           trap_code_ff,
  output var  logic [31:0]           bank_rdata,
  output var  logic                  bank_trap_ff
);
  localparam int OW = $clog2(SECT_WORDS);
  localparam int IW = OW + 4;

  typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_PROT, ST_DONE} fws_state_t;

  function automatic fws_pkg::fws_reg_t reg_decode(input fws_pkg::fws_addr_t a);
    case (a)
      fws_pkg::REG_CTRL_LO:  reg_decode = fws_pkg::SEL_CTRL_LO;
      fws_pkg::REG_OP_HI:    reg_decode = fws_pkg::SEL_OP_HI;
      fws_pkg::REG_SECT_LO:  reg_decode = fws_pkg::SEL_SECT_LO;
      fws_pkg::REG_SECT_HI:  reg_decode = fws_pkg::SEL_SECT_HI;
      fws_pkg::REG_DATA0_LO: reg_decode = fws_pkg::SEL_DATA0_LO;
      fws_pkg::REG_DATA0_HI: reg_decode = fws_pkg::SEL_DATA0_HI;
      fws_pkg::REG_DATA1_LO: reg_decode = fws_pkg::SEL_DATA1_LO;
      fws_pkg::REG_DATA1_HI: reg_decode = fws_pkg::SEL_DATA1_HI;
      fws_pkg::REG_ADDR_LO:  reg_decode = fws_pkg::SEL_ADDR_LO;
      fws_pkg::REG_ADDR_HI:  reg_decode = fws_pkg::SEL_ADDR_HI;
      fws_pkg::REG_ERROR:    reg_decode = fws_pkg::SEL_ERROR;
      default:               reg_decode = fws_pkg::SEL_NONE;
    endcase
  endfunction : reg_decode

  // Returns {in_range, test_sector, index}; test sector below user base
  function automatic logic [IW+1:0] map_addr(input fws_pkg::fws_addr_t a);
    fws_pkg::fws_addr_t off;
    logic [2:0]         sec;
    off = a - fws_pkg::USER_BASE;
    sec = off[OW+4:OW+2];
    if (a < fws_pkg::USER_BASE) begin
      map_addr = {(a[23:OW+2] == '0), 1'b1, 4'h0, a[OW+1:2]};
    end else begin
      map_addr = {(off[23:OW+5] == '0), 1'b0, {1'b0, sec} + 4'h1, off[OW+1:2]};
    end
  endfunction : map_addr

  function automatic fws_pkg::fws_op_t op_of(input logic [15:0] w);
    if (w[fws_pkg::SPR_BIT]) begin
      op_of = fws_pkg::OP_PROT;
    end else if (w[fws_pkg::SER_BIT]) begin
      op_of = fws_pkg::OP_ERASE;
    end else if (w[fws_pkg::DOUBLE_WORD_PROGRAM_SELECT_BIT]) begin
      op_of = fws_pkg::OP_DWORD;
    end else if (w[fws_pkg::WPG_BIT]) begin
      op_of = fws_pkg::OP_WORD;
    end else begin
      op_of = fws_pkg::OP_NONE;
    end
  endfunction : op_of

  fws_state_t        state_ff;
  fws_pkg::fws_op_t  op_ff;
  fws_pkg::fws_op_t  suspend_bit_op_ff;
  logic              lock_ff;
  logic              busy_ff;
  logic              wms_ff;
  logic              suspend_bit_ff;
  logic [3:0]        sel_ff;
  logic [7:0]        sect_sel_ff;
  logic [7:0]        sect_stat_ff;
  logic              bank_stat_ff;
  logic [31:0]       data0_ff;
  logic [31:0]       data1_ff;
  logic [31:0]       addr_ff;
  logic              err_ff;
  logic              sequence_error_flag_ff;
  logic              pend_err_ff;
  logic              pend_seq_ff;
  logic [IW-1:0]     pidx_ff;
  logic              half_ff;
  logic [2:0]        ptr_ff;
  logic [OW-1:0]     off_ff;
  logic              pre_ff;
  logic [31:0]       prot_ff [4];
  logic              tmr_load;
  logic              tmr_done;
  logic              arr_we;
  logic              arr_and;
  logic [IW-1:0]     arr_idx;
  logic [31:0]       arr_wdata;
  logic [IW+1:0]     tmap;
  logic [IW+1:0]     rmap;
  fws_pkg::fws_reg_t sel;
  fws_pkg::fws_op_t  wop;
  logic              wr_ok;
  logic              start_req;
  logic              launch;
  logic              resume;
  logic              suspend_bit_req;
  logic              prot_ok;
  logic              sweep_end;
  logic [15:0]       rd_mux;

  assign sel   = reg_decode(bus_req.addr);
  assign wop   = op_of(bus_req.wdata);
  assign tmap  = map_addr(addr_ff[23:0]);
  assign rmap  = map_addr(bank_addr);
  assign wr_ok = bus_req.wr && !lock_ff;
  // Software zero on the start bit is simply not a start
  assign start_req = wr_ok && sel == fws_pkg::SEL_OP_HI && bus_req.wdata[fws_pkg::WMS_BIT]
                     && !busy_ff && !err_ff;
  assign resume    = start_req && suspend_bit_ff && wop == suspend_bit_op_ff;
  assign launch    = start_req && !suspend_bit_ff && wop != fws_pkg::OP_NONE;
  // Suspend must reach a locked controller, so it bypasses the lock
  assign suspend_bit_req  = bus_req.wr && sel == fws_pkg::SEL_OP_HI && busy_ff
                     && bus_req.wdata[fws_pkg::SUSPEND_BIT_BIT] && op_ff != fws_pkg::OP_PROT;
  assign prot_ok   = (addr_ff[23:0] >= fws_pkg::PROT_HI && addr_ff[23:0] <= fws_pkg::PROT_LO)
                  || (addr_ff[23:0] >= fws_pkg::PROT_LO && addr_ff[23:0] <= fws_pkg::PROT_HI);
  assign sweep_end = (ptr_ff == 3'h7) && (off_ff == '1) && !pre_ff;
  assign tmr_load  = ((launch || resume) && (wop == fws_pkg::OP_WORD || wop == fws_pkg::OP_DWORD
                     || wop == fws_pkg::OP_PROT))
                  || (state_ff == ST_PROG && tmr_done && op_ff == fws_pkg::OP_DWORD && !half_ff);

  always_comb begin
    arr_we    = 1'b0;
    arr_and   = 1'b1;
    arr_idx   = pidx_ff;
    arr_wdata = data0_ff;
    if (state_ff == ST_PROG && tmr_done && !pend_err_ff) begin
      arr_we    = 1'b1;
      arr_idx   = pidx_ff | {{(IW-1){1'b0}}, half_ff};
      arr_wdata = half_ff ? data1_ff : data0_ff;
    end else if (state_ff == ST_ERASE) begin
      arr_we    = sect_sel_ff[ptr_ff];
      arr_and   = 1'b0;
      arr_idx   = {{1'b0, ptr_ff} + 4'h1, off_ff};
      arr_wdata = {4{pre_ff ? fws_pkg::PREPROG : fws_pkg::ERASED}};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      op_ff    <= fws_pkg::OP_NONE;
      half_ff  <= 1'b0;
      ptr_ff   <= 3'h0;
      off_ff   <= '0;
      pre_ff   <= 1'b1;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (launch || resume) begin
            op_ff   <= wop;
            half_ff <= 1'b0;
            unique case (wop)
              fws_pkg::OP_ERASE: state_ff <= ST_ERASE;
              fws_pkg::OP_PROT:  state_ff <= ST_PROT;
              default:           state_ff <= ST_PROG;
            endcase
            if (launch) begin
              ptr_ff <= 3'h0;
              off_ff <= '0;
              pre_ff <= 1'b1;
            end
          end
        end
        ST_PROG: begin
          if (suspend_bit_req) begin
            state_ff <= ST_IDLE;
          end else if (tmr_done) begin
            if (op_ff == fws_pkg::OP_DWORD && !half_ff) begin
              half_ff <= 1'b1;
            end else begin
              state_ff <= ST_DONE;
            end
          end
        end
        ST_ERASE: begin
          if (suspend_bit_req) begin
            state_ff <= ST_IDLE;
          end else if (sweep_end) begin
            state_ff <= ST_DONE;
          end else if (off_ff == '1 && !pre_ff) begin
            ptr_ff <= ptr_ff + 3'h1;
            pre_ff <= 1'b1;
            off_ff <= '0;
          end else if (off_ff == '1) begin
            pre_ff <= 1'b0;
            off_ff <= '0;
          end else begin
            off_ff <= off_ff + 1'b1;
          end
        end
        ST_PROT: begin
          if (tmr_done) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      lock_ff <= 1'b0;
      wms_ff  <= 1'b0;
    end else if (launch || resume) begin
      busy_ff <= 1'b1;
      lock_ff <= 1'b1;
      wms_ff  <= 1'b1;
    end else if (state_ff == ST_DONE || suspend_bit_req) begin
      busy_ff <= 1'b0;
      lock_ff <= 1'b0;
      wms_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      suspend_bit_ff    <= 1'b0;
      suspend_bit_op_ff <= fws_pkg::OP_NONE;
    end else if (suspend_bit_req) begin
      suspend_bit_ff    <= 1'b1;
      suspend_bit_op_ff <= op_ff;
    end else if (resume) begin
      suspend_bit_ff    <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff <= 4'h0;
    end else if (state_ff == ST_DONE) begin
      sel_ff <= 4'h0;
    end else if (wr_ok && sel == fws_pkg::SEL_OP_HI) begin
      sel_ff <= {bus_req.wdata[fws_pkg::SPR_BIT], bus_req.wdata[fws_pkg::SER_BIT],
                 bus_req.wdata[fws_pkg::DOUBLE_WORD_PROGRAM_SELECT_BIT], bus_req.wdata[fws_pkg::WPG_BIT]};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_err_ff <= 1'b0;
      pend_seq_ff <= 1'b0;
      pidx_ff     <= '0;
    end else if (launch) begin
      pidx_ff     <= tmap[IW-1:0];
      pend_err_ff <= ((wop == fws_pkg::OP_WORD || wop == fws_pkg::OP_DWORD)
                      && (!tmap[IW+1] || tmap[IW]))
                  || (wop == fws_pkg::OP_DWORD && addr_ff[2])
                  || (wop == fws_pkg::OP_ERASE && sect_sel_ff == 8'h00);
      pend_seq_ff <= 1'b0;
    end else if (state_ff == ST_PROT && !prot_ok) begin
      pend_seq_ff <= 1'b1;
    end
  end

  // Hardware set at completion wins over a same-cycle software clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_ff   <= 1'b0;
      sequence_error_flag_ff <= 1'b0;
    end else if (state_ff == ST_DONE) begin
      err_ff   <= err_ff | pend_err_ff | pend_seq_ff;
      sequence_error_flag_ff <= sequence_error_flag_ff | pend_seq_ff;
    end else if (wr_ok && sel == fws_pkg::SEL_ERROR) begin
      err_ff   <= err_ff & !bus_req.wdata[fws_pkg::ERR_BIT];
      sequence_error_flag_ff <= sequence_error_flag_ff & !bus_req.wdata[fws_pkg::SEQUENCE_ERROR_FLAG_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sect_sel_ff  <= 8'h00;
      sect_stat_ff <= 8'h00;
      bank_stat_ff <= 1'b0;
    end else if (state_ff == ST_ERASE) begin
      sect_stat_ff <= sect_stat_ff | sect_sel_ff;
      bank_stat_ff <= 1'b1;
    end else if (state_ff == ST_DONE && !pend_err_ff && !pend_seq_ff) begin
      sect_stat_ff <= 8'h00;
      bank_stat_ff <= 1'b0;
      sect_sel_ff  <= 8'h00;
    end else if (wr_ok && sel == fws_pkg::SEL_SECT_LO) begin
      sect_sel_ff  <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data0_ff <= 32'h00000000;
      data1_ff <= 32'h00000000;
      addr_ff  <= 32'h00000000;
    end else if (wr_ok) begin
      unique case (sel)
        fws_pkg::SEL_DATA0_LO: data0_ff[15:0]  <= bus_req.wdata;
        fws_pkg::SEL_DATA0_HI: data0_ff[31:16] <= bus_req.wdata;
        fws_pkg::SEL_DATA1_LO: data1_ff[15:0]  <= bus_req.wdata;
        fws_pkg::SEL_DATA1_HI: data1_ff[31:16] <= bus_req.wdata;
        fws_pkg::SEL_ADDR_LO:  addr_ff[15:0]   <= bus_req.wdata;
        fws_pkg::SEL_ADDR_HI:  addr_ff[31:16]  <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Protection words can only lose ones, like bank words being programmed; unlike the bank, they have no erase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        prot_ff[i] <= 32'hFFFFFFFF;
      end
    end else if (state_ff == ST_PROT && tmr_done && prot_ok) begin
      prot_ff[addr_ff[3:2]] <= prot_ff[addr_ff[3:2]] & data0_ff;
    end
  end

  always_comb begin
    rd_mux = fws_pkg::RESET_VAL;
    unique case (sel)
      fws_pkg::SEL_CTRL_LO: begin
        rd_mux[fws_pkg::LOCK_BIT] = lock_ff;
        rd_mux[fws_pkg::BUSY_BIT] = busy_ff && !lock_ff;
      end
      fws_pkg::SEL_OP_HI: begin
        rd_mux[fws_pkg::WMS_BIT]  = wms_ff;
        rd_mux[fws_pkg::SUSPEND_BIT_BIT] = suspend_bit_ff;
        rd_mux[fws_pkg::WPG_BIT]  = sel_ff[0];
        rd_mux[fws_pkg::DOUBLE_WORD_PROGRAM_SELECT_BIT] = sel_ff[1];
        rd_mux[fws_pkg::SER_BIT]  = sel_ff[2];
        rd_mux[fws_pkg::SPR_BIT]  = sel_ff[3];
      end
      fws_pkg::SEL_SECT_LO:  rd_mux[7:0] = sect_stat_ff | sect_sel_ff;
      fws_pkg::SEL_SECT_HI:  rd_mux[fws_pkg::BSTAT_BIT] = bank_stat_ff;
      fws_pkg::SEL_DATA0_LO: rd_mux = data0_ff[15:0];
      fws_pkg::SEL_DATA0_HI: rd_mux = data0_ff[31:16];
      fws_pkg::SEL_DATA1_LO: rd_mux = data1_ff[15:0];
      fws_pkg::SEL_DATA1_HI: rd_mux = data1_ff[31:16];
      fws_pkg::SEL_ADDR_LO:  rd_mux = addr_ff[15:0];
      fws_pkg::SEL_ADDR_HI:  rd_mux = addr_ff[31:16];
      fws_pkg::SEL_ERROR: begin
        rd_mux[fws_pkg::ERR_BIT]   = err_ff;
        rd_mux[fws_pkg::SEQUENCE_ERROR_FLAG_BIT] = sequence_error_flag_ff;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= fws_pkg::RESET_VAL;
      trap_ff  <= 1'b0;
    end else begin
      trap_ff  <= (bus_req.rd && lock_ff && sel != fws_pkg::SEL_CTRL_LO
                   && sel != fws_pkg::SEL_NONE)
               || (bank_rd && busy_ff);
      if (bus_req.rd && (!lock_ff || sel == fws_pkg::SEL_CTRL_LO)) begin
        rdata_ff <= rd_mux;
      end else begin
        rdata_ff <= fws_pkg::RESET_VAL;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trap_code_ff <= fws_pkg::RESET_VAL;
      bank_trap_ff <= 1'b0;
    end else begin
      bank_trap_ff <= bank_rd && busy_ff;
      if ((bank_rd && busy_ff) || (bus_req.rd && lock_ff && sel != fws_pkg::SEL_CTRL_LO
                                    && sel != fws_pkg::SEL_NONE)) begin
        trap_code_ff <= fws_pkg::TRAP_CODE;
      end
    end
  end

  fws_op_timer u_timer (
    .clock   (clock),
    .rst_b   (rst_b),
    .load    (tmr_load),
    .count   (PROG_CYCLES),
    .done_ff (tmr_done)
  );

  fws_flash_array #(.IW(IW)) u_array (
    .clock      (clock),
    .rst_b      (rst_b),
    .wr_en      (arr_we),
    .wr_and     (arr_and),
    .wr_idx     (arr_idx),
    .wr_data    (arr_wdata),
    .rd_en      (bank_rd),
    .rd_block   (busy_ff || !rmap[IW+1] || (rmap[IW] && !bootstrap)),
    .rd_idx     (rmap[IW-1:0]),
    .rd_data_ff (bank_rdata)
  );
endmodule : fws_flash_ctrl
`default_nettype wire

// >>> common/fws_pkg.sv
// Purpose: Shared constants and types of the flash write control sequencer
// Assumes: 16-bit register port with byte addresses, 20 MHz clock
`default_nettype none
package fws_pkg;

  typedef logic [23:0] fws_addr_t;

  localparam fws_addr_t REG_CTRL_LO  = 24'h080000;
  localparam fws_addr_t REG_OP_HI    = 24'h080002;
  localparam fws_addr_t REG_SECT_LO  = 24'h080004;
  localparam fws_addr_t REG_SECT_HI  = 24'h080006;
  localparam fws_addr_t REG_DATA0_LO = 24'h080008;
  localparam fws_addr_t REG_DATA0_HI = 24'h08000A;
  localparam fws_addr_t REG_DATA1_LO = 24'h08000C;
  localparam fws_addr_t REG_DATA1_HI = 24'h08000E;
  localparam fws_addr_t REG_ADDR_LO  = 24'h080010;
  localparam fws_addr_t REG_ADDR_HI  = 24'h080012;
  localparam fws_addr_t REG_ERROR    = 24'h080014;

  localparam int LOCK_BIT  = 4;
  localparam int BUSY_BIT  = 1;
  localparam int WMS_BIT   = 15;
  localparam int SUSPEND_BIT_BIT  = 14;
  localparam int WPG_BIT   = 13;
  localparam int DOUBLE_WORD_PROGRAM_SELECT_BIT  = 12;
  localparam int SER_BIT   = 11;
  localparam int SPR_BIT   = 8;
  localparam int BSTAT_BIT = 8;
  localparam int ERR_BIT   = 0;
  localparam int SEQUENCE_ERROR_FLAG_BIT = 1;

  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [15:0] TRAP_CODE = 16'h009B;
  localparam fws_addr_t   PROT_LO   = 24'h0E8FB0;
  localparam fws_addr_t   PROT_HI   = 24'h08DFBF;
  localparam fws_addr_t   USER_BASE = 24'h010000;
  localparam logic [7:0]  ERASED    = 8'hFF;
  localparam logic [7:0]  PREPROG   = 8'h00;

  localparam int          PROG_TIME_NS  = 500;
  localparam int          CLK_PERIOD_NS = 50;
  localparam logic [15:0] PROG_CYCLES   =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum {
    SEL_NONE, SEL_CTRL_LO, SEL_OP_HI, SEL_SECT_LO, SEL_SECT_HI, SEL_DATA0_LO,
    SEL_DATA0_HI, SEL_DATA1_LO, SEL_DATA1_HI, SEL_ADDR_LO, SEL_ADDR_HI, SEL_ERROR
  } fws_reg_t;

  typedef enum {OP_NONE, OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} fws_op_t;

  typedef struct packed {
    fws_addr_t   addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } fws_bus_req_t;

endpackage : fws_pkg
`default_nettype wire

// >>> rtl/fws_op_timer.sv
// Purpose: Down counter timing one program step
// Assumes: count of at least one cycle
// Notes:   done pulses for one cycle when the count expires
`timescale 1ns/1ps
`default_nettype none
module fws_op_timer (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output var  logic        done_ff
);
  logic [15:0] cnt_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
    end else if (load) begin
      cnt_ff <= count;
    end else if (cnt_ff != 16'h0000) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= !load && (cnt_ff == 16'h0001);
    end
  end
endmodule : fws_op_timer
`default_nettype wire

// >>> rtl/fws_flash_array.sv
// Purpose: Bank storage, sector 0 is the test sector
// Assumes: one write and one read per cycle
// Notes:   Storage has no reset, as a real array keeps its contents
`timescale 1ns/1ps
`default_nettype none
module fws_flash_array #(
  parameter int IW = 8
) (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic          wr_and,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  input  wire logic          rd_en,
  input  wire logic          rd_block,
  input  wire logic [IW-1:0] rd_idx,
  output var  logic [31:0]   rd_data_ff
);
  logic [31:0] mem [2**IW];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_and ? (mem[wr_idx] & wr_data) : wr_data;
    end
  end

  // Blocked reads return zero so stale data never leaks out
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 32'h00000000;
    end else if (rd_en) begin
      rd_data_ff <= rd_block ? 32'h00000000 : mem[rd_idx];
    end
  end
endmodule : fws_flash_array
`default_nettype wire

// >>> tb/fws_flash_ctrl_sva.sv
// Purpose: Port checks of the flash write sequencer
// Assumes: one clock, async active-low reset
// Notes:   Busy is not a port, so traps are tied to requests
`timescale 1ns/1ps
`default_nettype none
module fws_flash_ctrl_sva #(
  parameter int          SECT_WORDS  = 16,
  parameter logic [15:0] PROG_CYCLES = 16'h000A
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire fws_pkg::fws_bus_req_t bus_req,
  input  wire logic                  bootstrap,
  input  wire logic                  bank_rd,
  input  wire fws_pkg::fws_addr_t    bank_addr,
  input  wire logic [15:0]           rdata_ff,
  input  wire logic                  trap_ff,
  input  wire logic [15:0]           trap_code_ff,
  input  wire logic [31:0]           bank_rdata,
  input  wire logic                  bank_trap_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_code_set;
    trap_ff |=> trap_code_ff == 16'h009B;
  endproperty
  a_code_set: assert property (p_code_set) else $error("trap code not set");
  property p_code_hold;
    trap_code_ff == 16'h009B |=> $stable(trap_code_ff);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("trap code lost");
  property p_bank_cause;
    bank_trap_ff |-> $past(bank_rd) && trap_ff;
  endproperty
  a_bank_cause: assert property (p_bank_cause) else $error("bank trap no cause");
  property p_bank_data;
    bank_trap_ff |-> bank_rdata == 32'h0;
  endproperty
  a_bank_data: assert property (p_bank_data) else $error("busy bank data shown");
  property p_trap_cause;
    trap_ff |-> $past(bus_req.rd) || $past(bank_rd);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap with no read");
  property p_trap_data;
    trap_ff && !bank_trap_ff |-> rdata_ff == 16'h0000;
  endproperty
  a_trap_data: assert property (p_trap_data) else $error("locked data shown");
  property p_rdata_idle;
    !$past(bus_req.rd) |-> rdata_ff == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
  property p_status_open;
    $past(bus_req.rd && bus_req.addr == fws_pkg::REG_CTRL_LO)
      |-> trap_ff == bank_trap_ff && (rdata_ff & 16'hFFED) == 16'h0000;
  endproperty
  a_status_open: assert property (p_status_open) else $error("status read bad");
  property p_test_hidden;
    $past(bank_rd && bank_addr < fws_pkg::USER_BASE && !bootstrap) |-> bank_rdata == 32'h0;
  endproperty
  a_test_hidden: assert property (p_test_hidden) else $error("test sector seen");
endmodule : fws_flash_ctrl_sva
bind fws_flash_ctrl fws_flash_ctrl_sva #(.SECT_WORDS(SECT_WORDS), .PROG_CYCLES(PROG_CYCLES))
  u_sva (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .bootstrap(bootstrap),
  .bank_rd(bank_rd), .bank_addr(bank_addr), .rdata_ff(rdata_ff), .trap_ff(trap_ff),
  .trap_code_ff(trap_code_ff), .bank_rdata(bank_rdata), .bank_trap_ff(bank_trap_ff));
`default_nettype wire

// >>> tb/tb_fws_flash_ctrl.sv
// Purpose: Self-checking bench of the flash write sequencer
// Assumes: short program time so the run stays brief
// Notes:   Array has no reset, so the first user sector is erased first
`timescale 1ns/1ps
`default_nettype none
module tb_fws_flash_ctrl;
  logic                  clock = 1'h0;
  logic                  rst_b = 1'h0;
  fws_pkg::fws_bus_req_t req = '0;
  logic                  bank_rd = 1'h0;
  logic                  bootstrap = 1'h0;
  fws_pkg::fws_addr_t    bank_addr = '0;
  logic [15:0]           rdata_ff;
  logic [15:0]           trap_code_ff;
  logic                  trap_ff;
  logic                  bank_trap_ff;
  logic [31:0]           bank_rdata;
  logic [31:0]           d0;
  logic [31:0]           d1;
  logic [31:0]           mem [16];
  int                    fails = 0;
  int                    num_checks = 0;
  int                    idx;
  always #25 clock = ~clock;
  fws_flash_ctrl #(.SECT_WORDS(16), .PROG_CYCLES(16'h0002)) dut_u (
    .clock(clock), .rst_b(rst_b), .bus_req(req), .bootstrap(bootstrap),
    .bank_rd(bank_rd), .bank_addr(bank_addr), .rdata_ff(rdata_ff), .trap_ff(trap_ff),
    .trap_code_ff(trap_code_ff), .bank_rdata(bank_rdata), .bank_trap_ff(bank_trap_ff));
  task automatic complete_run;
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] burn(input logic [31:0] old, input logic [31:0] nw);
    return old & nw;
  endfunction : burn
  task automatic wr(input logic [23:0] ad, input logic [15:0] v);
    @(posedge clock);
    req.addr <= ad;
    req.wdata <= v;
    req.wr <= 1'h1;
    @(posedge clock);
    req.wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [23:0] ad, input logic [15:0] e, input logic te);
    @(posedge clock);
    req.addr <= ad;
    req.rd <= 1'h1;
    @(posedge clock);
    req.rd <= 1'h0;
    #1;
    chk("rdata", rdata_ff, e);
    chk("trap", trap_ff, te);
  endtask : rd
  task automatic brd(input logic [23:0] ad, input logic [31:0] e, input logic te);
    @(posedge clock);
    bank_addr <= ad;
    bank_rd <= 1'h1;
    @(posedge clock);
    bank_rd <= 1'h0;
    #1;
    chk("bank", bank_rdata, e);
    chk("btrap", bank_trap_ff, te);
  endtask : brd
  // Polls the lock flag; a hang ends the run
  task automatic idle;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      req.addr <= fws_pkg::REG_CTRL_LO;
      req.rd <= 1'h1;
      @(posedge clock);
      req.rd <= 1'h0;
      #1;
      if (rdata_ff === 16'h0000) return;
    end
    chk("timeout", 32'h1, 32'h0);
    complete_run();
  endtask : idle
  task automatic prog(input logic [23:0] ad, input logic [15:0] op);
    wr(fws_pkg::REG_DATA0_LO, d0[15:0]);
    wr(fws_pkg::REG_DATA0_HI, d0[31:16]);
    wr(fws_pkg::REG_DATA1_LO, d1[15:0]);
    wr(fws_pkg::REG_DATA1_HI, d1[31:16]);
    wr(fws_pkg::REG_ADDR_LO, ad[15:0]);
    wr(fws_pkg::REG_ADDR_HI, {8'h00, ad[23:16]});
    wr(fws_pkg::REG_OP_HI, op);
    idle();
  endtask : prog
  initial begin
    void'($urandom(32'h00BA));
    repeat (6) @(posedge clock);
    rst_b <= 1'h1;
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    rd(fws_pkg::REG_OP_HI, 16'h0000, 1'h0);
    rd(24'h080100, 16'h0000, 1'h0);
    brd(24'h000000, 32'h0, 1'h0);
    wr(fws_pkg::REG_OP_HI, 16'h2000);
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    rd(fws_pkg::REG_OP_HI, 16'h2000, 1'h0);
    wr(fws_pkg::REG_OP_HI, 16'h0000);
    wr(fws_pkg::REG_SECT_LO, 16'h0001);
    wr(fws_pkg::REG_OP_HI, 16'h8800);
    rd(fws_pkg::REG_CTRL_LO, 16'h0010, 1'h0);
    rd(fws_pkg::REG_OP_HI, 16'h0000, 1'h1);
    chk("code", trap_code_ff, 32'h009B);
    brd(24'h010000, 32'h0, 1'h1);
    wr(fws_pkg::REG_DATA0_LO, 16'h1234);
    wr(fws_pkg::REG_OP_HI, 16'h4800);
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    // A different operation may not start while the erase is suspended
    wr(fws_pkg::REG_OP_HI, 16'hA000);
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    wr(fws_pkg::REG_OP_HI, 16'h8800);
    rd(fws_pkg::REG_CTRL_LO, 16'h0010, 1'h0);
    idle();
    rd(fws_pkg::REG_OP_HI, 16'h0000, 1'h0);
    rd(fws_pkg::REG_DATA0_LO, 16'h0000, 1'h0);
    rd(fws_pkg::REG_ERROR, 16'h0000, 1'h0);
    for (int j = 0; j < 16; j++) begin
      mem[j] = 32'hFFFFFFFF;
      brd(24'h010000 + 24'(j * 4), mem[j], 1'h0);
    end
    // Test sector is never written, so an open read shows the raw array
    @(posedge clock);
    bootstrap <= 1'h1;
    brd(24'h000000, 32'hXXXXXXXX, 1'h0);
    // Random spots may repeat, so a zero must stay zero
    for (int k = 0; k < 6; k++) begin
      idx = $urandom_range(15);
      if (k[0]) idx[0] = 1'h0;
      d0 = $urandom;
      d1 = $urandom;
      prog(24'h010000 + 24'(idx * 4), k[0] ? 16'h9000 : 16'hA000);
      mem[idx] = burn(mem[idx], d0);
      if (k[0]) mem[idx + 1] = burn(mem[idx + 1], d1);
      for (int j = 0; j < 16; j++) brd(24'h010000 + 24'(j * 4), mem[j], 1'h0);
    end
    wr(fws_pkg::REG_ADDR_LO, 16'h0000);
    wr(fws_pkg::REG_ADDR_HI, 16'h0001);
    wr(fws_pkg::REG_OP_HI, 16'h8100);
    brd(24'h010004, 32'h0, 1'h1);
    idle();
    rd(fws_pkg::REG_ERROR, 16'h0003, 1'h0);
    wr(fws_pkg::REG_OP_HI, 16'hA000);
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    wr(fws_pkg::REG_ERROR, 16'h0003);
    rd(fws_pkg::REG_ERROR, 16'h0000, 1'h0);
    @(posedge clock);
    rst_b <= 1'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    rd(fws_pkg::REG_CTRL_LO, 16'h0000, 1'h0);
    chk("code", trap_code_ff, 32'h0);
    complete_run();
  end
endmodule : tb_fws_flash_ctrl
`default_nettype wire
